// ### hw/spi_digipot.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Write-protect low blocks every nonvolatile setting write.
// - Serial input bits are sampled on serial clock rising edges.
// - Serial output is three-state, driven only while sending read data.
// - Wiper position decodes to exactly one of 256 tap selects.
// - Write-wiper instruction loads the wiper serially from host data.
// - Transfer instruction loads the wiper from the selected setting.
// - Step instruction moves the wiper one step per clock pulse.
// - After reset the wiper loads from setting zero of bank zero.
// - Sixteen 8-bit setting slots in four banks of four.
// - A nonvolatile setting write completes within ten milliseconds.
// - Status bit 0 reads one while a nonvolatile write runs.
// - First byte is type code, two zero bits, then address.
// - Command runs only if both address bits match the straps.
// - Second byte holds opcode, register pointer and bank select.
// - Register pointer picks register 0 to 3 within the bank.
// - Wiper transfers use bank zero only; other banks read and write.
// - Read data shifts out on serial clock falling edges.
// - Pause low while clock low suspends; high while clock low resumes.
// - Nonvolatile save starts when select rises after a full write.
module spi_digipot (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic cs_n_in,
   input wire logic sck_in,
   input wire logic si_in,
   input wire logic hold_n_in,
   input wire logic wp_n_in,
   input wire logic [1:0] address_strap_pins_in,
   output logic so_out,
   output logic so_oe_out,
   output logic nv_busy_flag_out,
   output logic [7:0] wiper_position_out,
   output logic [pot_pkg::TAP_CNT-1:0] tap_select_out
);
   // ==========================================================
   // Pin synchronisers.
   logic cs_n_s;
   logic sck_s;
   logic si_s;
   logic hold_n_s;
   logic wp_n_s;
   logic [1:0] strap_s;
   logic [5:0] raw_pins;
   logic [5:0] sync_pins;
   assign raw_pins = {cs_n_in, sck_in, si_in, hold_n_in, wp_n_in, 1'b0};
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_sync
         pin_sync u_sync (
            .clk_in(clk_in),
            .resetn_in(resetn_in),
            .ce_in(ce_in),
            .pin_in(g == 0 ? 1'b1 : raw_pins[g]),
            .init_in(1'b1),
            .level_out(sync_pins[g])
         );
      end
   endgenerate
   assign cs_n_s = sync_pins[5];
   assign sck_s = sync_pins[4];
   assign si_s = sync_pins[3];
   assign hold_n_s = sync_pins[2];
   assign wp_n_s = sync_pins[1];
   logic [1:0] strap_m1_reg;
   logic [1:0] strap_m2_reg;
   logic [1:0] strap_m3_reg;
   logic [1:0] strap_reg;
   // ==========================================================
   // Strap pins pass three stages; a change counts once two and three agree.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         strap_m1_reg <= 2'h0;
         strap_m2_reg <= 2'h0;
         strap_m3_reg <= 2'h0;
         strap_reg <= 2'h0;
      end else if (ce_in) begin
         strap_m1_reg <= address_strap_pins_in;
         strap_m2_reg <= strap_m1_reg;
         strap_m3_reg <= strap_m2_reg;
         if (strap_m2_reg == strap_m3_reg) begin
            strap_reg <= strap_m3_reg;
         end
      end
   end
   assign strap_s = strap_reg;
   // ==========================================================
   // Edge detection with pause gating.
   logic sck_d_reg;
   logic cs_n_d_reg;
   logic paused_reg;
   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic cs_rise;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sck_d_reg <= 1'b1;
         cs_n_d_reg <= 1'b1;
         paused_reg <= 1'b0;
      end else if (ce_in) begin
         sck_d_reg <= sck_s;
         cs_n_d_reg <= cs_n_s;
         if (!sck_s) begin
            paused_reg <= !hold_n_s;
         end
      end
   end
   assign sck_rise = sck_s && !sck_d_reg && !paused_reg;
   assign sck_fall = !sck_s && sck_d_reg && !paused_reg;
   assign cs_fall = !cs_n_s && cs_n_d_reg;
   assign cs_rise = cs_n_s && !cs_n_d_reg;
   // ==========================================================
   // Frame decoder.
   pot_pkg::frame_state_e state_reg;
   logic [7:0] shift_reg;
   logic [2:0] bit_cnt_reg;
   logic [3:0] opcode_reg;
   logic [3:0] slot_idx_reg;
   logic [7:0] out_reg;
   logic [7:0] rx_byte;
   logic byte_done;
   logic [7:0] slot_mem [pot_pkg::SLOT_CNT];
   logic [7:0] wiper_position_reg;
   assign rx_byte = {shift_reg[6:0], si_s};
   assign byte_done = sck_rise && (bit_cnt_reg == pot_pkg::BIT_LAST);
   logic id_ok;
   assign id_ok = (rx_byte[7:4] == pot_pkg::TYPE_CODE)
      && (rx_byte[3:2] == 2'h0)
      && (rx_byte[1:0] == strap_s);
   logic pending_save_reg;
   logic [7:0] save_data_reg;
   logic [3:0] save_idx_reg;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_reg <= pot_pkg::ST_IGNORE;
         shift_reg <= 8'h00;
         bit_cnt_reg <= 3'h0;
         opcode_reg <= 4'h0;
         slot_idx_reg <= 4'h0;
      end else if (ce_in) begin
         if (cs_n_s) begin
            state_reg <= pot_pkg::ST_IGNORE;
            bit_cnt_reg <= 3'h0;
         end else if (cs_fall) begin
            state_reg <= pot_pkg::ST_ID;
            bit_cnt_reg <= 3'h0;
         end else if (sck_rise) begin
            shift_reg <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (byte_done) begin
               unique case (state_reg)
                  pot_pkg::ST_ID: begin
                     state_reg <= id_ok ? pot_pkg::ST_INSTR
                        : pot_pkg::ST_IGNORE;
                  end
                  pot_pkg::ST_INSTR: begin
                     opcode_reg <= rx_byte[7:4];
                     slot_idx_reg <= {rx_byte[1:0], rx_byte[3:2]};
                     unique case (rx_byte[7:4])
                        pot_pkg::OP_WR_WIPER, pot_pkg::OP_WR_SLOT:
                           state_reg <= pot_pkg::ST_DATA_IN;
                        pot_pkg::OP_RD_WIPER, pot_pkg::OP_RD_SLOT,
                        pot_pkg::OP_STATUS:
                           state_reg <= pot_pkg::ST_DATA_OUT;
                        pot_pkg::OP_STEP:
                           state_reg <= pot_pkg::ST_STEP;
                        default:
                           state_reg <= pot_pkg::ST_DONE;
                     endcase
                  end
                  pot_pkg::ST_STEP: state_reg <= pot_pkg::ST_STEP;
                  pot_pkg::ST_IGNORE: state_reg <= pot_pkg::ST_IGNORE;
                  default: state_reg <= pot_pkg::ST_DONE;
               endcase
            end
         end
      end
   end
   // ==========================================================
   // Read data output.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         out_reg <= 8'h00;
         so_out <= 1'b0;
         so_oe_out <= 1'b0;
      end else if (ce_in) begin
         if (cs_n_s || state_reg != pot_pkg::ST_DATA_OUT) begin
            so_oe_out <= 1'b0;
            if (byte_done && state_reg == pot_pkg::ST_INSTR) begin
               unique case (rx_byte[7:4])
                  pot_pkg::OP_RD_WIPER: out_reg <= wiper_position_reg;
                  pot_pkg::OP_RD_SLOT:
                     out_reg <= slot_mem[{rx_byte[1:0], rx_byte[3:2]}];
                  default: out_reg <= {7'h00, nv_busy_flag_out};
               endcase
            end
         end else if (sck_fall) begin
            so_out <= out_reg[7];
            so_oe_out <= 1'b1;
            out_reg <= {out_reg[6:0], 1'b0};
         end
      end
   end
   // ==========================================================
   // Wiper position.
   logic boot_reg;
   logic step_ok;
   logic bank0;
   assign step_ok = state_reg == pot_pkg::ST_STEP && sck_rise;
   assign bank0 = slot_idx_reg[3:2] == pot_pkg::BANK_ZERO;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         boot_reg <= 1'b1;
         wiper_position_reg <= 8'h00;
      end else if (ce_in) begin
         boot_reg <= 1'b0;
         if (boot_reg) begin
            wiper_position_reg <= slot_mem[pot_pkg::DEFAULT_SLOT];
         end else if (step_ok) begin
            if (si_s && wiper_position_reg != pot_pkg::WIPER_MAX) begin
               wiper_position_reg <= wiper_position_reg + 8'h01;
            end else if (!si_s
               && wiper_position_reg != pot_pkg::WIPER_MIN) begin
               wiper_position_reg <= wiper_position_reg - 8'h01;
            end
         end else if (byte_done && state_reg == pot_pkg::ST_DATA_IN
            && opcode_reg == pot_pkg::OP_WR_WIPER) begin
            wiper_position_reg <= rx_byte;
         end else if (cs_rise && state_reg == pot_pkg::ST_DONE
            && opcode_reg == pot_pkg::OP_SLOT_TO_WIPER && bank0) begin
            wiper_position_reg <= slot_mem[slot_idx_reg];
         end
      end
   end
   assign wiper_position_out = wiper_position_reg;
   tap_decoder u_taps (
      .position_in(wiper_position_reg),
      .tap_select_out(tap_select_out)
   );
   // ==========================================================
   // Nonvolatile save.
   logic [pot_pkg::NV_CNT_W-1:0] nv_cnt_reg;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pending_save_reg <= 1'b0;
         save_data_reg <= 8'h00;
         save_idx_reg <= 4'h0;
      end else if (ce_in) begin
         if (cs_fall) begin
            pending_save_reg <= 1'b0;
         end else if (byte_done && state_reg == pot_pkg::ST_DATA_IN
            && opcode_reg == pot_pkg::OP_WR_SLOT) begin
            pending_save_reg <= 1'b1;
            save_data_reg <= rx_byte;
            save_idx_reg <= slot_idx_reg;
         end else if (byte_done && state_reg == pot_pkg::ST_INSTR
            && rx_byte[7:4] == pot_pkg::OP_WIPER_TO_SLOT
            && rx_byte[1:0] == pot_pkg::BANK_ZERO) begin
            pending_save_reg <= 1'b1;
            save_data_reg <= wiper_position_reg;
            save_idx_reg <= {pot_pkg::BANK_ZERO, rx_byte[3:2]};
         end else if (cs_rise) begin
            pending_save_reg <= 1'b0;
         end
      end
   end
   logic start_save;
   assign start_save = cs_rise && pending_save_reg && wp_n_s
      && !nv_busy_flag_out;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         nv_busy_flag_out <= 1'b0;
         nv_cnt_reg <= '0;
      end else if (ce_in) begin
         if (start_save) begin
            nv_busy_flag_out <= 1'b1;
            nv_cnt_reg <= pot_pkg::NV_CNT_W'(pot_pkg::NV_WRITE_CYC - 1);
         end else if (nv_busy_flag_out) begin
            if (nv_cnt_reg == '0) begin
               nv_busy_flag_out <= 1'b0;
            end else begin
               nv_cnt_reg <= nv_cnt_reg - 1'b1;
            end
         end
      end
   end
   always_ff @(posedge clk_in) begin
      if (ce_in && start_save) begin
         slot_mem[save_idx_reg] <= save_data_reg;
      end
   end
endmodule // spi_digipot

// ### hw/pot_pkg.sv
package pot_pkg;
   // ==========================================================
   // Frame layout and codes.
   localparam int BYTE_W = 8;
   localparam int SLOT_CNT = 16;
   localparam int TAP_CNT = 256;
   localparam logic [3:0] TYPE_CODE = 4'h5; // Arbitrary value.
   localparam logic [3:0] OP_RD_WIPER = 4'h9;
   localparam logic [3:0] OP_WR_WIPER = 4'hA;
   localparam logic [3:0] OP_RD_SLOT = 4'hB;
   localparam logic [3:0] OP_WR_SLOT = 4'hC;
   localparam logic [3:0] OP_SLOT_TO_WIPER = 4'hD;
   localparam logic [3:0] OP_WIPER_TO_SLOT = 4'hE;
   localparam logic [3:0] OP_STEP = 4'h2;
   localparam logic [3:0] OP_STATUS = 4'h5;
   localparam logic [1:0] BANK_ZERO = 2'h0;
   localparam logic [7:0] WIPER_MAX = 8'hFF;
   localparam logic [7:0] WIPER_MIN = 8'h00;
   localparam logic [3:0] DEFAULT_SLOT = 4'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // ==========================================================
   // Timing.
   localparam int CLK_MHZ = 125;
   localparam int NV_WRITE_MS = 10;
   localparam int NV_WRITE_CYC = NV_WRITE_MS * CLK_MHZ * 1000;
   localparam int NV_CNT_W = 21;
   // ==========================================================
   // Frame states.
   typedef enum logic [2:0] {
      ST_ID = 3'b000,
      ST_INSTR = 3'b001,
      ST_DATA_IN = 3'b010,
      ST_DATA_OUT = 3'b011,
      ST_STEP = 3'b100,
      ST_DONE = 3'b101,
      ST_IGNORE = 3'b110
   } frame_state_e;
endpackage

// ### hw/pin_sync.sv
`timescale 1ns/10ps
module pin_sync (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic pin_in,
   input wire logic init_in,
   output logic level_out
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   // ==========================================================
   // Three stages; the level moves once stages two and three agree.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
         level_out <= 1'b1;
      end else if (ce_in) begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            level_out <= s3_reg;
         end
      end
   end
   logic unused_init;
   assign unused_init = init_in;
endmodule // pin_sync

// ### hw/tap_decoder.sv
`timescale 1ns/10ps
module tap_decoder (
   input wire logic [7:0] position_in,
   output logic [pot_pkg::TAP_CNT-1:0] tap_select_out
);
   // ==========================================================
   // One-hot tap select, exactly one bit per position.
   genvar i;
   generate
      for (i = 0; i < pot_pkg::TAP_CNT; i++) begin : g_tap
         assign tap_select_out[i] = (position_in == 8'(i));
      end
   endgenerate
endmodule // tap_decoder

// ### tb/spi_digipot_sva.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker.
module spi_digipot_sva (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic cs_n_in,
   input wire logic sck_in,
   input wire logic si_in,
   input wire logic hold_n_in,
   input wire logic wp_n_in,
   input wire logic [1:0] address_strap_pins_in,
   input wire logic so_out,
   input wire logic so_oe_out,
   input wire logic nv_busy_flag_out,
   input wire logic [7:0] wiper_position_out,
   input wire logic [pot_pkg::TAP_CNT-1:0] tap_select_out
);
   int unsigned since_fall;
   int unsigned cs_hi_cnt;
   int unsigned busy_cnt;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         since_fall <= 0;
         cs_hi_cnt <= 0;
         busy_cnt <= 0;
      end else begin
         since_fall <= $fell(sck_in) ? 0 : since_fall + 1;
         cs_hi_cnt <= cs_n_in ? cs_hi_cnt + 1 : 0;
         busy_cnt <= nv_busy_flag_out ? busy_cnt + 1 : 0;
      end
   end
   a_tap_one_hot: assert property ($changed(wiper_position_out) |->
      $onehot(tap_select_out) && tap_select_out[wiper_position_out])
      else $error("tap select not one-hot of wiper");
   a_so_float_idle: assert property (cs_n_in [*8] |-> !so_oe_out)
      else $error("serial output driven while deselected");
   a_so_after_fall: assert property (
      $changed(so_out) && so_oe_out |-> since_fall <= 8)
      else $error("serial output moved away from a clock fall");
   a_no_save_wp: assert property (
      $rose(nv_busy_flag_out) |-> wp_n_in && $past(wp_n_in, 8))
      else $error("save started under write protect");
   a_save_at_cs: assert property (
      $rose(nv_busy_flag_out) |-> cs_n_in && $past(cs_n_in, 3))
      else $error("save started before select rose");
   a_busy_bound: assert property (
      nv_busy_flag_out |-> busy_cnt <= pot_pkg::NV_WRITE_CYC)
      else $error("save longer than allowed");
   a_wiper_idle: assert property (
      cs_hi_cnt > 12 |-> $stable(wiper_position_out))
      else $error("wiper moved outside a frame");
   a_pause_freeze: assert property ((!hold_n_in) [*8] |->
      $stable(wiper_position_out) && $stable(so_out))
      else $error("state moved during pause");
   c_save: cover property ($rose(nv_busy_flag_out));
   c_read: cover property ($rose(so_oe_out));
   c_pause: cover property ((!hold_n_in) [*8]);
endmodule // spi_digipot_sva
bind spi_digipot spi_digipot_sva u_sva (.clk_in(clk_in),
   .resetn_in(resetn_in), .ce_in(ce_in), .cs_n_in(cs_n_in),
   .sck_in(sck_in), .si_in(si_in), .hold_n_in(hold_n_in),
   .wp_n_in(wp_n_in), .address_strap_pins_in(address_strap_pins_in),
   .so_out(so_out), .so_oe_out(so_oe_out),
   .nv_busy_flag_out(nv_busy_flag_out),
   .wiper_position_out(wiper_position_out),
   .tap_select_out(tap_select_out));

// ### tb/spi_host_model.sv
`timescale 1ns/10ps
// ==========================================================
// Host controller model for the serial pins.
module spi_host_model (
   input wire logic clk_in,
   input wire logic so_in,
   input wire logic so_oe_in,
   output logic cs_n_out,
   output logic sck_out,
   output logic si_out,
   output logic hold_n_out
);
   initial begin
      cs_n_out = 1'b1;
      sck_out = 1'b0;
      si_out = 1'b0;
      hold_n_out = 1'b1;
   end
   task automatic half();
      repeat (10) @(negedge clk_in);
   endtask
   task automatic xfer(input logic [23:0] f, input int n, input bit p,
         output logic [7:0] rd);
      rd = 8'h00;
      cs_n_out = 1'b0;
      half();
      for (int i = 0; i < n; i++) begin
         si_out = f[23-i];
         half();
         if (i >= 16) rd[23-i] = so_oe_in ? so_in : 1'bz;
         if (p && i == 18) begin
            hold_n_out = 1'b0;
            half();
            sck_out = 1'b1;
            half();
            sck_out = 1'b0;
            half();
            hold_n_out = 1'b1;
            half();
         end
         sck_out = 1'b1;
         half();
         sck_out = 1'b0;
      end
      cs_n_out = 1'b1;
      si_out = ~si_out;
      repeat (4) half();
   endtask
endmodule // spi_host_model

// ### tb/spi_digipot_tb.sv
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench.
module spi_digipot_tb;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic wp_n_in = 1'b1;
   logic [1:0] straps = 2'h2;
   logic cs_n, sck, si, hold_n, so, so_oe, busy;
   logic [7:0] wiper;
   logic [7:0] rd;
   logic [7:0] bad [3];
   int failures = 0;
   int checks_done = 0;
   always #4 clk_in = ~clk_in;
   spi_digipot u_dut (.clk_in(clk_in), .resetn_in(resetn_in),
      .ce_in(1'b1), .cs_n_in(cs_n), .sck_in(sck), .si_in(si),
      .hold_n_in(hold_n), .wp_n_in(wp_n_in),
      .address_strap_pins_in(straps), .so_out(so), .so_oe_out(so_oe),
      .nv_busy_flag_out(busy), .wiper_position_out(wiper),
      .tap_select_out());
   spi_host_model u_host (.clk_in(clk_in), .so_in(so), .so_oe_in(so_oe),
      .cs_n_out(cs_n), .sck_out(sck), .si_out(si), .hold_n_out(hold_n));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic op(input logic [3:0] c, input logic [3:0] s,
         input logic [7:0] d, input int n);
      u_host.xfer({pot_pkg::TYPE_CODE, 2'h0, straps, c, s, d}, n, 1'b0, rd);
      repeat (12) @(negedge clk_in);
   endtask
   task automatic do_reset();
      resetn_in = 1'b0;
      repeat (16) @(negedge clk_in);
      resetn_in = 1'b1;
      repeat (10) @(negedge clk_in);
   endtask
   task automatic results();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #400000;
      failures++;
      results();
   end
   initial begin
      bad[0] = {pot_pkg::TYPE_CODE, 2'h0, 2'h1};
      bad[1] = {pot_pkg::TYPE_CODE, 2'h1, 2'h2};
      bad[2] = {~pot_pkg::TYPE_CODE, 2'h0, 2'h2};
      do_reset();
      op(pot_pkg::OP_WR_WIPER, 4'h0, 8'h12, 24);
      chk(wiper, 8'h12);
      op(pot_pkg::OP_RD_WIPER, 4'h0, 8'h00, 24);
      chk(rd, 8'h12);
      op(pot_pkg::OP_WR_WIPER, 4'h0, 8'hFD, 24);
      op(pot_pkg::OP_STEP, 4'h0, 8'hFF, 20);
      chk(wiper, 8'hFF);
      op(pot_pkg::OP_STEP, 4'h0, 8'h00, 19);
      chk(wiper, 8'hFC);
      op(pot_pkg::OP_WR_WIPER, 4'h0, 8'h01, 24);
      op(pot_pkg::OP_STEP, 4'h0, 8'h00, 19);
      chk(wiper, 8'h00);
      u_host.xfer({pot_pkg::TYPE_CODE, 2'h0, straps, pot_pkg::OP_STEP,
         4'h0, 8'hFF}, 19, 1'b1, rd);
      chk(wiper, 8'h03);
      foreach (bad[i]) begin
         u_host.xfer({bad[i], pot_pkg::OP_WR_WIPER, 12'h077}, 24, 1'b0, rd);
         chk(wiper, 8'h03);
      end
      op(pot_pkg::OP_WR_SLOT, 4'h0, 8'h3C, 24);
      chk({7'h0, busy}, 8'h01);
      op(pot_pkg::OP_STATUS, 4'h1, 8'h00, 24);
      chk(rd, 8'h01);
      op(pot_pkg::OP_RD_SLOT, 4'h0, 8'h00, 24);
      chk(rd, 8'h3C);
      op(pot_pkg::OP_SLOT_TO_WIPER, 4'h0, 8'h00, 16);
      chk(wiper, 8'h3C);
      op(pot_pkg::OP_WR_WIPER, 4'h0, 8'h44, 24);
      op(pot_pkg::OP_SLOT_TO_WIPER, 4'h1, 8'h00, 16);
      chk(wiper, 8'h44);
      do_reset();
      chk(wiper, 8'h3C);
      wp_n_in = 1'b0;
      op(pot_pkg::OP_WR_SLOT, 4'h0, 8'h55, 24);
      op(pot_pkg::OP_WIPER_TO_SLOT, 4'h0, 8'h00, 16);
      chk({7'h0, busy}, 8'h00);
      wp_n_in = 1'b1;
      op(pot_pkg::OP_RD_SLOT, 4'h0, 8'h00, 24);
      chk(rd, 8'h3C);
      op(pot_pkg::OP_WR_SLOT, 4'hB, 8'hA5, 24);
      op(pot_pkg::OP_RD_SLOT, 4'hB, 8'h00, 24);
      chk(rd, 8'hA5);
      op(pot_pkg::OP_RD_SLOT, 4'h0, 8'h00, 24);
      chk(rd, 8'h3C);
      results();
   end
endmodule // spi_digipot_tb
